// >>> rtl/relay_driver_fault_supervisor.sv
// Purpose: Fault supervisor and output gating of a three-channel low-side relay driver
// Assumes: All pin inputs synchronous to sys_clk_in; regulator level given as two comparator flags
// Notes: Open-drain pins are split into level, enable and readback; enable high means pin pulled low
// Functional notes
// - Either enable input keeps the device running; both low means sleep.
// - Heartbeat input is edge-sensitive; missing edge before timeout is a watchdog fault.
// - Watchdog count-up ends on any heartbeat edge or on the upper trip count.
// - Count-up length sets heartbeat timeout; count-down length sets reset pulse width.
// - Watchdog fault gives a repeating train of low reset pulses.
// - Other faults hold reset low for as long as they last.
// - After regulator comes up, fault stays until power-on timer trips.
// - Drive requests are active high and read low when left open.
// - Regulator below lockout threshold raises a fault and pulls reset low.
// - Without faults regulator on, reset high, outputs follow requests.
// - Overcurrent latches only its channel off until request goes low then high.
// - Watchdog alarm keeps regulator on, pulses reset, holds all outputs off.
// - Lockout holds reset low, outputs off, and reset low until power-on delay.
// - Thermal shutdown turns regulator off, pulls reset low, outputs off, top priority.
// - Sleep turns supplies off, releases reset, holds all outputs off.
// - After reset releases, outputs stay off until first heartbeat edge.
// - Lockout flag clears only above threshold plus hysteresis, restarting power-on timer.
// - Timeout about 200 ms per uF, reset pulse about 14 ms per uF.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module relay_driver_fault_supervisor #(
  parameter logic [31:0] POR_CYCLES_INIT = 32'(relay_supervisor_pkg::POR_CYCLES),
  parameter logic [31:0] WD_UP_CYCLES_INIT = 32'(relay_supervisor_pkg::WD_UP_CYCLES),
  parameter logic [31:0] WD_DOWN_CYCLES_INIT = 32'(relay_supervisor_pkg::WD_DOWN_CYCLES)
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Enables and monitors
  input wire logic logic_enable_in,
  input wire logic battery_enable_in,
  input wire logic thermal_shutdown_in,
  input wire logic reg_below_undervoltage_lockout_in,
  input wire logic reg_above_undervoltage_lockout_hys_in,
  // Microcontroller side
  input wire logic wdog_kick_input_in,
  input wire logic [relay_supervisor_pkg::CHANNELS-1:0] drive_request_in,
  input wire logic reset_out_n_in,
  output logic reset_out_n_out,
  output logic reset_out_n_oe_out,
  // Supplies
  output logic internal_supply_on_out,
  output logic regulator_on_out,
  // Load side
  input wire logic [relay_supervisor_pkg::CHANNELS-1:0] overcurrent_in,
  input wire logic [relay_supervisor_pkg::CHANNELS-1:0] driver_out_in,
  output logic [relay_supervisor_pkg::CHANNELS-1:0] driver_out_out,
  output logic [relay_supervisor_pkg::CHANNELS-1:0] driver_out_oe_out
);
  import relay_supervisor_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] por_cycles_q;
  logic [31:0] wd_up_cycles_q;
  logic [31:0] wd_down_cycles_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] status;
  logic setup_phase;
  logic write_access;

  function automatic logic addr_mapped(input logic [7:0] a);
    if (a == CTRL_ADDR || a == POR_CYC_ADDR || a == WD_UP_CYC_ADDR) begin
      return 1'b1;
    end else if (a == WD_DOWN_CYC_ADDR || a == STATUS_ADDR) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  assign setup_phase = psel_in && !penable_in;
  assign write_access = psel_in && penable_in && pwrite_in && addr_mapped(paddr_in);

  // Zero wait states: read data and error are prepared during setup
  assign pready_out = 1'b1;
  assign prdata_out = prdata_q;
  assign pslverr_out = pslverr_q;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ctrl_q <= CTRL_RESET;
      por_cycles_q <= POR_CYCLES_INIT;
      wd_up_cycles_q <= WD_UP_CYCLES_INIT;
      wd_down_cycles_q <= WD_DOWN_CYCLES_INIT;
    end else if (write_access) begin
      if (paddr_in == CTRL_ADDR) begin
        ctrl_q <= {31'h0000_0000, pwdata_in[CTRL_WD_DISABLE_BIT]};
      end else if (paddr_in == POR_CYC_ADDR) begin
        por_cycles_q <= pwdata_in;
      end else if (paddr_in == WD_UP_CYC_ADDR) begin
        wd_up_cycles_q <= pwdata_in;
      end else if (paddr_in == WD_DOWN_CYC_ADDR) begin
        wd_down_cycles_q <= pwdata_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      prdata_q <= RDATA_UNMAPPED;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      pslverr_q <= !addr_mapped(paddr_in);
      if (pwrite_in) begin
        prdata_q <= RDATA_UNMAPPED;
      end else if (paddr_in == CTRL_ADDR) begin
        prdata_q <= ctrl_q;
      end else if (paddr_in == POR_CYC_ADDR) begin
        prdata_q <= por_cycles_q;
      end else if (paddr_in == WD_UP_CYC_ADDR) begin
        prdata_q <= wd_up_cycles_q;
      end else if (paddr_in == WD_DOWN_CYC_ADDR) begin
        prdata_q <= wd_down_cycles_q;
      end else if (paddr_in == STATUS_ADDR) begin
        prdata_q <= status;
      end else begin
        prdata_q <= RDATA_UNMAPPED;
      end
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic enabled;
  logic sleep;
  logic undervoltage_lockout_q;
  logic [31:0] por_cnt_q;
  logic por_done;
  logic hard_fault;

  assign enabled = logic_enable_in || battery_enable_in;
  assign sleep = !enabled;

  // Regulator is off in sleep and thermal shutdown, so it counts as low then
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || sleep || thermal_shutdown_in || reg_below_undervoltage_lockout_in) begin
      undervoltage_lockout_q <= 1'b1;
    end else if (reg_above_undervoltage_lockout_hys_in) begin
      undervoltage_lockout_q <= 1'b0;
    end
  end

  // Power-on timer restarts from zero whenever the regulator is not up
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || undervoltage_lockout_q || sleep || thermal_shutdown_in) begin
      por_cnt_q <= 32'h0000_0000;
    end else if (!por_done) begin
      por_cnt_q <= por_cnt_q + 32'h0000_0001;
    end
  end

  assign por_done = por_cnt_q >= por_cycles_q;
  assign hard_fault = thermal_shutdown_in || undervoltage_lockout_q || !por_done;

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  wd_phase_e wd_phase_q;
  logic [31:0] wd_cnt_q;
  logic wd_alarm_q;
  logic wd_pulse_q;
  logic kick_prev_q;
  logic kick_edge;
  logic wd_run;

  assign kick_edge = wdog_kick_input_in ^ kick_prev_q;
  // Disable bit stands in for a shorted timer node
  assign wd_run = enabled && !hard_fault && !ctrl_q[CTRL_WD_DISABLE_BIT];

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      kick_prev_q <= 1'b0;
    end else begin
      kick_prev_q <= wdog_kick_input_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !wd_run) begin
      wd_phase_q <= WD_COUNT_UP;
      wd_cnt_q <= 32'h0000_0000;
      wd_pulse_q <= 1'b0;
    end else begin
      case (wd_phase_q)
        WD_COUNT_UP: begin
          if (kick_edge) begin
            wd_phase_q <= WD_COUNT_DOWN;
            wd_cnt_q <= 32'h0000_0000;
          end else if (wd_cnt_q + 32'h0000_0001 >= wd_up_cycles_q) begin
            wd_phase_q <= WD_COUNT_DOWN;
            wd_cnt_q <= wd_down_cycles_q;
            wd_pulse_q <= 1'b1;
          end else begin
            wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
          end
        end
        WD_COUNT_DOWN: begin
          if (wd_cnt_q <= 32'h0000_0001) begin
            wd_phase_q <= WD_COUNT_UP;
            wd_cnt_q <= 32'h0000_0000;
            wd_pulse_q <= 1'b0;
          end else begin
            wd_cnt_q <= wd_cnt_q - 32'h0000_0001;
          end
        end
        default: begin
          wd_phase_q <= WD_COUNT_UP;
        end
      endcase
    end
  end

  // Alarm stays up between pulses until the heartbeat returns
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !wd_run) begin
      wd_alarm_q <= 1'b0;
    end else if (wd_phase_q == WD_COUNT_UP && !kick_edge && wd_cnt_q + 32'h0000_0001 >= wd_up_cycles_q) begin
      wd_alarm_q <= 1'b1;
    end else if (kick_edge && wd_phase_q == WD_COUNT_UP) begin
      wd_alarm_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Reset pin and output arming
  // ----------------------------------------
  logic reset_low;
  logic armed_q;
  logic reset_oe_q;

  assign reset_low = !sleep && (hard_fault || wd_pulse_q);

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      reset_oe_q <= 1'b0;
    end else begin
      reset_oe_q <= reset_low;
    end
  end

  // Any reset or sleep disarms; the first heartbeat edge after release arms
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      armed_q <= 1'b0;
    end else if (reset_low || sleep || wd_alarm_q) begin
      armed_q <= kick_edge && wd_alarm_q && !reset_low && !sleep && wd_phase_q == WD_COUNT_UP;
    end else if (kick_edge) begin
      armed_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Output channels
  // ----------------------------------------
  logic [CHANNELS-1:0] oc_latch_q;
  logic [CHANNELS-1:0] drive_on_q;
  logic outputs_allowed;

  assign outputs_allowed = armed_q && !sleep && !hard_fault && !wd_alarm_q;

  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      // Set wins over the clear by a low request
      always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
          oc_latch_q[ch] <= 1'b0;
        end else if (overcurrent_in[ch]) begin
          oc_latch_q[ch] <= 1'b1;
        end else if (!drive_request_in[ch]) begin
          oc_latch_q[ch] <= 1'b0;
        end
      end

      always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
          drive_on_q[ch] <= 1'b0;
        end else begin
          drive_on_q[ch] <= outputs_allowed && drive_request_in[ch] && !oc_latch_q[ch] && !overcurrent_in[ch];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Supplies and pins
  // ----------------------------------------
  logic int_on_q;
  logic reg_on_q;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      int_on_q <= 1'b0;
      reg_on_q <= 1'b0;
    end else begin
      int_on_q <= enabled;
      reg_on_q <= enabled && !thermal_shutdown_in;
    end
  end

  assign internal_supply_on_out = int_on_q;
  assign regulator_on_out = reg_on_q;
  assign reset_out_n_out = 1'b0;
  assign reset_out_n_oe_out = reset_oe_q;
  assign driver_out_out = '0;
  assign driver_out_oe_out = drive_on_q;

  always_comb begin
    status = 32'h0000_0000;
    status[ST_SLEEP_BIT] = sleep;
    status[ST_TSD_BIT] = thermal_shutdown_in;
    status[ST_UNDERVOLTAGE_LOCKOUT_BIT] = undervoltage_lockout_q;
    status[ST_POR_BIT] = !por_done;
    status[ST_WD_ALARM_BIT] = wd_alarm_q;
    status[ST_ARMED_BIT] = armed_q;
    status[ST_RESET_PIN_BIT] = reset_out_n_in;
    status[ST_OC_LSB +: CHANNELS] = oc_latch_q;
    status[ST_OUT_PIN_LSB +: CHANNELS] = driver_out_in;
    status[ST_OUT_ON_LSB +: CHANNELS] = drive_on_q;
  end
endmodule

// >>> common/relay_supervisor_pkg.sv
// Purpose: Shared constants of the relay driver fault supervisor
// Assumes: 200 MHz system clock, 32-bit APB register bus
// Notes: Timer defaults model the capacitor timers as cycle counts
package relay_supervisor_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] POR_CYC_ADDR = 8'h04;
  localparam logic [7:0] WD_UP_CYC_ADDR = 8'h08;
  localparam logic [7:0] WD_DOWN_CYC_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_WD_DISABLE_BIT = 0;
  localparam int ST_SLEEP_BIT = 0;
  localparam int ST_TSD_BIT = 1;
  localparam int ST_UNDERVOLTAGE_LOCKOUT_BIT = 2;
  localparam int ST_POR_BIT = 3;
  localparam int ST_WD_ALARM_BIT = 4;
  localparam int ST_ARMED_BIT = 5;
  localparam int ST_RESET_PIN_BIT = 6;
  localparam int ST_OC_LSB = 8;
  localparam int ST_OUT_PIN_LSB = 12;
  localparam int ST_OUT_ON_LSB = 16;
  localparam int CHANNELS = 3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
  // ----------------------------------------
  // Timing: ms per uF scaled by a nominal capacitance in nF
  // ----------------------------------------
  localparam longint CLK_HZ = 200000000;
  localparam longint CAP_NF = 220;
  localparam longint POR_MS_PER_UF = 200;
  localparam longint WD_MS_PER_UF = 200;
  localparam longint WDR_MS_PER_UF = 14;
  localparam longint POR_CYCLES = POR_MS_PER_UF * CAP_NF * (CLK_HZ / 1000) / 1000;
  localparam longint WD_UP_CYCLES = WD_MS_PER_UF * CAP_NF * (CLK_HZ / 1000) / 1000;
  localparam longint WD_DOWN_CYCLES = WDR_MS_PER_UF * CAP_NF * (CLK_HZ / 1000) / 1000;
  // ----------------------------------------
  // Watchdog phases
  // ----------------------------------------
  typedef enum logic {WD_COUNT_UP, WD_COUNT_DOWN} wd_phase_e;
endpackage

// >>> dv/relay_supervisor_properties.sv
// Purpose: Port-level properties of the relay driver fault supervisor
// Assumes: Timer registers keep their parameter values
// Notes: A run-length counter stands in for long repetitions
`timescale 1ns/1ps
module relay_supervisor_properties #(
  parameter logic [31:0] POR_CYCLES_INIT = 32'h28,
  parameter logic [31:0] WD_DOWN_CYCLES_INIT = 32'h5
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Enables and monitors
  input wire logic logic_enable_in,
  input wire logic battery_enable_in,
  input wire logic thermal_shutdown_in,
  input wire logic reg_below_undervoltage_lockout_in,
  input wire logic reg_above_undervoltage_lockout_hys_in,
  // Pins
  input wire logic [relay_supervisor_pkg::CHANNELS-1:0] drive_request_in,
  input wire logic [relay_supervisor_pkg::CHANNELS-1:0] overcurrent_in,
  input wire logic reset_out_n_oe_out,
  input wire logic internal_supply_on_out,
  input wire logic regulator_on_out,
  input wire logic [relay_supervisor_pkg::CHANNELS-1:0] driver_out_oe_out
);
  import relay_supervisor_pkg::*;
  localparam int por_lo = 31;
  localparam int por_hi = 37;
  logic en;
  logic [31:0] hi_q;
  assign en = logic_enable_in || battery_enable_in;
  // --------------------------------
  // Length of the current reset-low run
  // --------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      hi_q <= 32'h0;
    end else begin
      hi_q <= reset_out_n_oe_out ? hi_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  a_sleep_quiet: assert property (!en |=> !reset_out_n_oe_out && !internal_supply_on_out
    && !regulator_on_out && driver_out_oe_out == 3'h0) else $error("sleep not quiet");
  a_either_enable: assert property ((logic_enable_in != battery_enable_in) |=> internal_supply_on_out)
    else $error("single enable not running");
  a_tsd_off: assert property (en && thermal_shutdown_in |=> !regulator_on_out && internal_supply_on_out
    && reset_out_n_oe_out && driver_out_oe_out == 3'h0) else $error("thermal state wrong");
  // Lockout flag is registered, so the pin answers on the second edge
  a_undervoltage_lockout_hold: assert property (en && reg_below_undervoltage_lockout_in |-> ##2 reset_out_n_oe_out
    && driver_out_oe_out == 3'h0) else $error("lockout state wrong");
  a_oc_cut: assert property ((overcurrent_in != 3'h0) |=>
    (driver_out_oe_out & $past(overcurrent_in)) == 3'h0) else $error("overcurrent channel still on");
  a_req_gate: assert property ((driver_out_oe_out & ~$past(drive_request_in)) == 3'h0)
    else $error("output on without request");
  a_out_reset: assert property (driver_out_oe_out != 3'h0 |-> !reset_out_n_oe_out)
    else $error("output on while reset low");
  a_wd_width: assert property ($fell(reset_out_n_oe_out) && en |->
    hi_q == WD_DOWN_CYCLES_INIT || hi_q >= POR_CYCLES_INIT) else $error("reset low run length wrong");
  a_por_wait: assert property ($rose(reg_above_undervoltage_lockout_hys_in) && en && !thermal_shutdown_in && !reg_below_undervoltage_lockout_in
    |=> reset_out_n_oe_out [*8] ##[por_lo:por_hi] !reset_out_n_oe_out) else $error("power-on delay wrong");
  c_wd_pulse: cover property ($fell(reset_out_n_oe_out) && hi_q == WD_DOWN_CYCLES_INIT);
  c_oc: cover property (overcurrent_in != 3'h0 && driver_out_oe_out != 3'h0);
  c_sleep: cover property (!en ##1 !en);
endmodule
bind relay_driver_fault_supervisor relay_supervisor_properties #(.POR_CYCLES_INIT(POR_CYCLES_INIT),
  .WD_DOWN_CYCLES_INIT(WD_DOWN_CYCLES_INIT)) u_props (.sys_clk_in, .reset_in, .logic_enable_in,
  .battery_enable_in, .thermal_shutdown_in, .reg_below_undervoltage_lockout_in, .reg_above_undervoltage_lockout_hys_in, .drive_request_in,
  .overcurrent_in, .reset_out_n_oe_out, .internal_supply_on_out, .regulator_on_out, .driver_out_oe_out);

// >>> dv/relay_mcu_model.sv
// Purpose: Microcontroller heartbeat and pin levels
// Assumes: Reset pin pulled up by the regulator, loads pulled to battery
// Notes: Tie mode feeds the reset pin back as the heartbeat
`timescale 1ns/1ps
module relay_mcu_model (
  // Clock and control
  input wire logic clk_in,
  input wire logic kick_en_in,
  input wire logic tie_in,
  // Pins
  input wire logic rst_oe_in,
  input wire logic reg_on_in,
  input wire logic [2:0] out_oe_in,
  output logic kick_out,
  output logic rst_pin_out,
  output logic [2:0] out_pin_out
);
  logic [3:0] cnt_q = 4'h0;
  logic tog_q = 1'h0;
  // Pull-up hangs on the regulator, so sleep and overtemperature read low
  assign rst_pin_out = !rst_oe_in && reg_on_in;
  assign out_pin_out = ~out_oe_in;
  assign kick_out = tie_in ? rst_pin_out : tog_q;
  // Toggle every ten cycles, well inside the timeout
  always_ff @(posedge clk_in) begin
    cnt_q <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
    if (kick_en_in && cnt_q == 4'h9) begin
      tog_q <= !tog_q;
    end
  end
endmodule

// >>> dv/test_relay_driver_fault_supervisor.sv
// Purpose: Self-checking bench of the relay driver fault supervisor
// Assumes: Timers shortened to 40/30/5 cycles; watchdog timeout rewritten to 32 at start
// Notes: Pins packed as regulator, supply, reset drive, outputs
`timescale 1ns/1ps
module test_relay_driver_fault_supervisor;
  import relay_supervisor_pkg::*;
  logic sys_clk_in = 1'h0, reset_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
  logic [7:0] paddr_in = 8'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, er, wdog_kick_input_in, reset_out_n_in, reset_out_n_oe_out;
  logic logic_enable_in = 1'h1, battery_enable_in = 1'h1, thermal_shutdown_in = 1'h0;
  logic reg_below_undervoltage_lockout_in = 1'h0, reg_above_undervoltage_lockout_hys_in = 1'h1, kick_en = 1'h0, tie = 1'h0;
  logic internal_supply_on_out, regulator_on_out;
  logic [2:0] drive_request_in = 3'h0, overcurrent_in = 3'h0, driver_out_in, driver_out_oe_out;
  logic [5:0] pins;
  int errors = 0, cmp_count = 0, n;
  assign pins = {regulator_on_out, internal_supply_on_out, reset_out_n_oe_out, driver_out_oe_out};
  initial begin
    forever #2.5 sys_clk_in = !sys_clk_in;
  end
  relay_driver_fault_supervisor #(.POR_CYCLES_INIT(32'h28), .WD_UP_CYCLES_INIT(32'h1e),
    .WD_DOWN_CYCLES_INIT(32'h5)) u_dut (.sys_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .logic_enable_in, .battery_enable_in,
    .thermal_shutdown_in, .reg_below_undervoltage_lockout_in, .reg_above_undervoltage_lockout_hys_in, .wdog_kick_input_in, .drive_request_in,
    .reset_out_n_in, .reset_out_n_out(), .reset_out_n_oe_out, .internal_supply_on_out, .regulator_on_out,
    .overcurrent_in, .driver_out_in, .driver_out_out(), .driver_out_oe_out);
  relay_mcu_model u_mcu (.clk_in(sys_clk_in), .kick_en_in(kick_en), .tie_in(tie), .rst_oe_in(reset_out_n_oe_out),
    .reg_on_in(regulator_on_out), .out_oe_in(driver_out_oe_out), .kick_out(wdog_kick_input_in),
    .rst_pin_out(reset_out_n_in), .out_pin_out(driver_out_in));
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge sys_clk_in);
    psel_in <= 1'h1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'h1;
    do begin
      @(posedge sys_clk_in);
    end while (pready_out !== 1'h1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask
  task automatic wait_oe(input logic v, input int lim, output int c);
    c = 0;
    while (reset_out_n_oe_out !== v && c < lim) begin
      @(posedge sys_clk_in);
      c++;
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole sequence needs about 540 cycles; allow several times that
  initial begin
    #10000;
    errors++;
    give_verdict();
  end
  initial begin
    cyc(10);
    reset_in <= 1'h0;
    drive_request_in <= 3'h5;
    cyc(3);
    check("por hold", 32'h1, reset_out_n_oe_out);
    apb(1'h0, CTRL_ADDR, 32'h0, rd, er);
    check("ctrl reset", CTRL_RESET, rd);
    apb(1'h0, POR_CYC_ADDR, 32'h0, rd, er);
    check("por cycles", 32'h28, rd);
    apb(1'h1, WD_UP_CYC_ADDR, 32'h20, rd, er);
    apb(1'h0, WD_UP_CYC_ADDR, 32'h0, rd, er);
    check("wd up cycles", 32'h20, rd);
    apb(1'h0, 8'h14, 32'h0, rd, er);
    check("unmapped err", 32'h1, er);
    cyc(40);
    check("unarmed", 6'h30, pins);
    kick_en <= 1'h1;
    cyc(25);
    check("follow req", 6'h35, pins);
    overcurrent_in <= 3'h1;
    cyc(1);
    overcurrent_in <= 3'h0;
    cyc(3);
    check("oc latch", 6'h34, pins);
    apb(1'h0, STATUS_ADDR, 32'h0, rd, er);
    check("status", 32'(1 << ST_ARMED_BIT | 1 << ST_RESET_PIN_BIT | 1 << ST_OC_LSB | 3 << ST_OUT_PIN_LSB
      | 4 << ST_OUT_ON_LSB), rd);
    check("status err", 32'h0, er);
    drive_request_in <= 3'h4;
    cyc(2);
    drive_request_in <= 3'h5;
    cyc(3);
    check("oc rearm", 6'h35, pins);
    kick_en <= 1'h0;
    wait_oe(1'h1, 60, n);
    wait_oe(1'h0, 50, n);
    check("pulse width", 32'h5, n);
    check("wd outputs", 6'h30, pins);
    wait_oe(1'h1, 50, n);
    check("pulse gap", 32'h20, n);
    kick_en <= 1'h1;
    cyc(40);
    check("wd recover", 6'h35, pins);
    reg_below_undervoltage_lockout_in <= 1'h1;
    reg_above_undervoltage_lockout_hys_in <= 1'h0;
    cyc(3);
    check("undervoltage_lockout", 6'h38, pins);
    reg_below_undervoltage_lockout_in <= 1'h0;
    cyc(60);
    check("undervoltage_lockout hyst", 6'h38, pins);
    reg_above_undervoltage_lockout_hys_in <= 1'h1;
    cyc(30);
    check("por delay", 6'h38, pins);
    cyc(30);
    check("undervoltage_lockout recover", 6'h35, pins);
    thermal_shutdown_in <= 1'h1;
    cyc(3);
    check("tsd", 6'h18, pins);
    thermal_shutdown_in <= 1'h0;
    cyc(70);
    check("tsd recover", 6'h35, pins);
    apb(1'h1, CTRL_ADDR, 32'h1, rd, er);
    logic_enable_in <= 1'h0;
    cyc(3);
    check("one enable", 6'h35, pins);
    battery_enable_in <= 1'h0;
    kick_en <= 1'h0;
    tie <= 1'h1;
    cyc(3);
    check("sleep", 6'h00, pins);
    logic_enable_in <= 1'h1;
    cyc(120);
    check("tied wdog", 6'h35, pins);
    give_verdict();
  end
endmodule
